// [shared/rtcsi_pkg.sv]
package rtcsi_pkg;

	// ------------------------------------------------------------------
	// source count and common bit order of every flag register except the 4-bit bad entry mirror
	// ------------------------------------------------------------------
	localparam int RTCSI_NSRC     = 5;
	localparam int RTCSI_B_GRANT  = 0;
	localparam int RTCSI_B_MATCH  = 1;
	localparam int RTCSI_B_ONE_HZ = 2;
	localparam int RTCSI_B_HMS    = 3;
	localparam int RTCSI_B_DMY    = 4;
	localparam int RTCSI_NBAD     = 4;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] RTCSI_OFF_CTRL  = 8'h00;
	localparam logic [7:0] RTCSI_OFF_FLAGS = 8'h18;
	localparam logic [7:0] RTCSI_OFF_CLR   = 8'h1C;
	localparam logic [7:0] RTCSI_OFF_IEN   = 8'h20;
	localparam logic [7:0] RTCSI_OFF_IDIS  = 8'h24;
	localparam logic [7:0] RTCSI_OFF_IMSK  = 8'h28;
	localparam logic [7:0] RTCSI_OFF_BAD   = 8'h2C;

	// ------------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------------
	localparam int RTCSI_CR_UPD_TIME_POS = 0;
	localparam int RTCSI_CR_UPD_DATE_POS = 1;
	localparam int RTCSI_CR_HMS_SEL_LSB  = 8;
	localparam int RTCSI_CR_DMY_SEL_LSB  = 16;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [RTCSI_NSRC-1:0] RTCSI_FLAGS_RST = 5'h00;
	localparam logic [RTCSI_NSRC-1:0] RTCSI_IEN_RST   = 5'h00;
	localparam logic [RTCSI_NBAD-1:0] RTCSI_BAD_RST   = 4'h0;
	localparam logic [31:0]           RTCSI_RD_RST    = 32'h0000_0000;

	// ------------------------------------------------------------------
	// event selections
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RTCSI_HMS_MINUTE   = 2'b00,
		RTCSI_HMS_HOUR     = 2'b01,
		RTCSI_HMS_MIDNIGHT = 2'b10,
		RTCSI_HMS_NOON     = 2'b11
	} rtcsi_hms_sel_t;

	typedef enum logic [1:0]
	{
		RTCSI_DMY_WEEK  = 2'b00,
		RTCSI_DMY_MONTH = 2'b01,
		RTCSI_DMY_YEAR  = 2'b10,
		RTCSI_DMY_YEAR2 = 2'b11
	} rtcsi_dmy_sel_t;

endpackage : rtcsi_pkg

// [hdl/rtcsi_flag_bank.sv]
`timescale 1ns/100ps
module rtcsi_flag_bank
	import rtcsi_pkg::*;
#(
	parameter int N = RTCSI_NSRC
)
(
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         ce_i,
	input  wire logic [N-1:0] set_i,
	input  wire logic [N-1:0] clr_i,
	output logic      [N-1:0] flags_o
);

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	generate
		if (N < 1 || N > RTCSI_NSRC)
		begin : g_bad_n
			$error("rtcsi_flag_bank: N out of range");
		end
	endgenerate

	// ------------------------------------------------------------------
	// one sticky cell per source
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_cell
			logic flag_r;
			logic flag_nxt;
			// a set in the clearing cycle wins so no event is lost
			assign flag_nxt = set_i[gi] | (flag_r & ~clr_i[gi]);
			always_ff @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
					flag_r <= RTCSI_FLAGS_RST[gi];
				else if (ce_i)
					flag_r <= flag_nxt;
			end
			assign flags_o[gi] = flag_r;
		end
	endgenerate

endmodule : rtcsi_flag_bank

// [hdl/rtcsi_top.sv]
`timescale 1ns/100ps
module rtcsi_top
	import rtcsi_pkg::*;
#(
	parameter int AW = 8
)
(
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  ce_i,
	input  wire logic [AW-1:0]         paddr_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  update_grant_i,
	input  wire logic                  alarm_match_i,
	input  wire logic                  one_hz_tick_i,
	input  wire logic                  minute_tick_i,
	input  wire logic                  hour_tick_i,
	input  wire logic                  midnight_tick_i,
	input  wire logic                  noon_tick_i,
	input  wire logic                  week_tick_i,
	input  wire logic                  month_tick_i,
	input  wire logic                  year_tick_i,
	input  wire logic [RTCSI_NBAD-1:0] bad_entry_i,
	output logic                       time_update_req_o,
	output logic                       date_update_req_o,
	output logic                       irq_o
);

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	generate
		if (AW < 8)
		begin : g_bad_aw
			$error("rtcsi_top: AW must be at least 8");
		end
	endgenerate

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [31:0]           prdata_r;
	logic                  pready_r;
	logic                  pslverr_r;
	logic                  irq_r;
	logic                  upd_time_r;
	logic                  upd_date_r;
	rtcsi_hms_sel_t        hms_sel_r;
	rtcsi_dmy_sel_t        dmy_sel_r;
	logic [RTCSI_NSRC-1:0] ien_r;
	logic [RTCSI_NSRC-1:0] ien_nxt;
	logic [RTCSI_NBAD-1:0] bad_r;
	logic [RTCSI_NSRC-1:0] flags_w;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic logic rtcsi_hit(input logic [AW-1:0] a,
		input logic [7:0] off);
		rtcsi_hit = (a == AW'(off));
	endfunction : rtcsi_hit

	wire hit_ctrl  = rtcsi_hit(paddr_i, RTCSI_OFF_CTRL);
	wire hit_flags = rtcsi_hit(paddr_i, RTCSI_OFF_FLAGS);
	wire hit_clr   = rtcsi_hit(paddr_i, RTCSI_OFF_CLR);
	wire hit_ien   = rtcsi_hit(paddr_i, RTCSI_OFF_IEN);
	wire hit_idis  = rtcsi_hit(paddr_i, RTCSI_OFF_IDIS);
	wire hit_imsk  = rtcsi_hit(paddr_i, RTCSI_OFF_IMSK);
	wire hit_bad   = rtcsi_hit(paddr_i, RTCSI_OFF_BAD);
	wire mapped_w  = hit_ctrl | hit_flags | hit_clr | hit_ien
		| hit_idis | hit_imsk | hit_bad;

	// read data is caught in the setup cycle so prdata is a flop;
	// a flag that rises during the access phase shows on the next read
	wire setup_w  = psel_i & ~penable_i;
	wire access_w = psel_i & penable_i & pready_r;
	wire wr_w     = access_w & pwrite_i;
	wire ctrl_wr  = wr_w & hit_ctrl;
	wire clr_wr   = wr_w & hit_clr;
	wire ien_wr   = wr_w & hit_ien;
	wire idis_wr  = wr_w & hit_idis;
	wire [RTCSI_NSRC-1:0] wsrc_w = pwdata_i[RTCSI_NSRC-1:0];

	// ------------------------------------------------------------------
	// event selection
	// ------------------------------------------------------------------
	wire hms_hit_w =
		(hms_sel_r == RTCSI_HMS_MINUTE)   ? minute_tick_i   :
		(hms_sel_r == RTCSI_HMS_HOUR)     ? hour_tick_i     :
		(hms_sel_r == RTCSI_HMS_MIDNIGHT) ? midnight_tick_i :
		noon_tick_i;
	// both upper codes pick the year change
	wire dmy_hit_w =
		(dmy_sel_r == RTCSI_DMY_WEEK)  ? week_tick_i  :
		(dmy_sel_r == RTCSI_DMY_MONTH) ? month_tick_i :
		year_tick_i;

	logic [RTCSI_NSRC-1:0] ev_set_w;
	assign ev_set_w[RTCSI_B_GRANT]  = update_grant_i;
	assign ev_set_w[RTCSI_B_MATCH]  = alarm_match_i;
	assign ev_set_w[RTCSI_B_ONE_HZ] = one_hz_tick_i;
	assign ev_set_w[RTCSI_B_HMS]    = hms_hit_w;
	assign ev_set_w[RTCSI_B_DMY]    = dmy_hit_w;

	wire [RTCSI_NSRC-1:0] clr_vec_w = clr_wr ? wsrc_w : RTCSI_FLAGS_RST;

	rtcsi_flag_bank #(
		.N       (RTCSI_NSRC)
	) u_flags (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.ce_i    (ce_i),
		.set_i   (ev_set_w),
		.clr_i   (clr_vec_w),
		.flags_o (flags_w)
	);

	// ------------------------------------------------------------------
	// enable state and read mux
	// ------------------------------------------------------------------
	assign ien_nxt = ien_wr  ? (ien_r | wsrc_w) :
		idis_wr ? (ien_r & ~wsrc_w) :
		ien_r;

	wire [31:0] ctrl_rd_w =
		({31'h0, upd_time_r} << RTCSI_CR_UPD_TIME_POS)
		| ({31'h0, upd_date_r} << RTCSI_CR_UPD_DATE_POS)
		| ({30'h0, hms_sel_r} << RTCSI_CR_HMS_SEL_LSB)
		| ({30'h0, dmy_sel_r} << RTCSI_CR_DMY_SEL_LSB);

	wire [31:0] rd_w =
		hit_ctrl  ? ctrl_rd_w :
		hit_flags ? {27'h0, flags_w} :
		hit_imsk  ? {27'h0, ien_r} :
		hit_bad   ? {28'h0, bad_r} :
		RTCSI_RD_RST;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			prdata_r  <= RTCSI_RD_RST;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (ce_i)
		begin
			pready_r <= setup_w;
			if (setup_w)
			begin
				prdata_r  <= pwrite_i ? RTCSI_RD_RST : rd_w;
				pslverr_r <= ~mapped_w;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			upd_time_r <= 1'b0;
			upd_date_r <= 1'b0;
			hms_sel_r  <= RTCSI_HMS_MINUTE;
			dmy_sel_r  <= RTCSI_DMY_WEEK;
		end
		else if (ce_i && ctrl_wr)
		begin
			upd_time_r <= pwdata_i[RTCSI_CR_UPD_TIME_POS];
			upd_date_r <= pwdata_i[RTCSI_CR_UPD_DATE_POS];
			hms_sel_r  <= rtcsi_hms_sel_t'(
				pwdata_i[RTCSI_CR_HMS_SEL_LSB +: 2]);
			dmy_sel_r  <= rtcsi_dmy_sel_t'(
				pwdata_i[RTCSI_CR_DMY_SEL_LSB +: 2]);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ien_r <= RTCSI_IEN_RST;
			bad_r <= RTCSI_BAD_RST;
			irq_r <= 1'b0;
		end
		else if (ce_i)
		begin
			ien_r <= ien_nxt;
			bad_r <= bad_entry_i;
			irq_r <= |(flags_w & ien_r);
		end
	end

	assign prdata_o          = prdata_r;
	assign pready_o          = pready_r;
	assign pslverr_o         = pslverr_r;
	assign time_update_req_o = upd_time_r;
	assign date_update_req_o = upd_date_r;
	assign irq_o             = irq_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_grant;
		ce_i && update_grant_i |=> flags_w[RTCSI_B_GRANT];
	endproperty
	a_grant: assert property (p_grant)
		else $error("grant flag not raised");

	property p_set_wins;
		ce_i && (ev_set_w != 5'h00)
			|=> ((flags_w & $past(ev_set_w)) == $past(ev_set_w));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost on flag set");

	property p_sticky;
		ce_i && !clr_wr
			|=> ((flags_w & $past(flags_w)) == $past(flags_w));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without clear");

	property p_hms_noon;
		ce_i && hms_sel_r == RTCSI_HMS_NOON && noon_tick_i
			|=> flags_w[RTCSI_B_HMS];
	endproperty
	a_hms_noon: assert property (p_hms_noon)
		else $error("noon event not latched");

	property p_hms_midnight;
		ce_i && hms_sel_r == RTCSI_HMS_MIDNIGHT && midnight_tick_i
			|=> flags_w[RTCSI_B_HMS];
	endproperty
	a_hms_midnight: assert property (p_hms_midnight)
		else $error("midnight event not latched");

	property p_dmy_year;
		ce_i && dmy_sel_r == RTCSI_DMY_YEAR2 && year_tick_i
			|=> flags_w[RTCSI_B_DMY];
	endproperty
	a_dmy_year: assert property (p_dmy_year)
		else $error("year event not latched");

	property p_clear;
		ce_i && clr_wr && ev_set_w == 5'h00
			|=> ((flags_w & $past(wsrc_w)) == 5'h00);
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear write left flag set");

	property p_ien;
		ce_i && ien_wr
			|=> ((ien_r & $past(wsrc_w)) == $past(wsrc_w))
			&& ((ien_r & ~$past(wsrc_w)) == ($past(ien_r) & ~$past(wsrc_w)));
	endproperty
	a_ien: assert property (p_ien)
		else $error("enable write wrong");

	property p_idis;
		ce_i && idis_wr
			|=> ((ien_r & $past(wsrc_w)) == 5'h00)
			&& ((ien_r & ~$past(wsrc_w)) == ($past(ien_r) & ~$past(wsrc_w)));
	endproperty
	a_idis: assert property (p_idis)
		else $error("disable write wrong");

	property p_imsk_read;
		ce_i && setup_w && !pwrite_i && hit_imsk
			|=> prdata_o == {27'h0, $past(ien_r)} && pready_o;
	endproperty
	a_imsk_read: assert property (p_imsk_read)
		else $error("mask read wrong");

	property p_irq;
		ce_i |=> irq_o == (|($past(flags_w) & $past(ien_r)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level wrong");

	property p_bad;
		// a reset released at this edge still holds the mirror at zero
		ce_i && rstn_i |=> bad_r == $past(bad_entry_i);
	endproperty
	a_bad: assert property (p_bad)
		else $error("invalid entry flags stale");

endmodule : rtcsi_top

// [verif/rtcsi_tb.sv]
`timescale 1ns/100ps
module testbench
	import rtcsi_pkg::*;
;
	// ------------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------------
	logic        clk_i;
	logic        rstn_i;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  ev;
	logic [3:0]  bad;
	logic        treq;
	logic        dreq;
	logic        irq;
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	// ev: 0 grant 1 match 2 second 3..6 min/hour/midnight/noon 7..9 w/m/y
	rtcsi_top #(.AW(8)) DUT (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.update_grant_i(ev[0]), .alarm_match_i(ev[1]),
		.one_hz_tick_i(ev[2]), .minute_tick_i(ev[3]),
		.hour_tick_i(ev[4]), .midnight_tick_i(ev[5]),
		.noon_tick_i(ev[6]), .week_tick_i(ev[7]),
		.month_tick_i(ev[8]), .year_tick_i(ev[9]),
		.bad_entry_i(bad), .time_update_req_o(treq),
		.date_update_req_o(dreq), .irq_o(irq)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------------
	// compare, bus and event helpers
	// ------------------------------------------------------------------
	task complete_run;
		$display("err_count=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// a hang is cut short here and counted as a mismatch
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	// request held until pready is seen high, released after that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// values seen here are those sampled at this rising edge
		@(posedge clk_i);
		while (pready !== 1'b1)
			@(posedge clk_i);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		chk32(rd, exp);
		chk1(er, 1'b0);
	endtask : rdc

	task pulse(input int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
	endtask : pulse

	task irq_is(input logic exp);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk1(irq, exp);
	endtask : irq_is

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_reset;
		rdc(RTCSI_OFF_FLAGS, 32'h0);
		rdc(RTCSI_OFF_IMSK, 32'h0);
		rdc(RTCSI_OFF_BAD, 32'h0);
		chk1(irq, 1'b0);
	endtask : t_reset

	task t_flags;
		pulse(0);
		pulse(1);
		pulse(2);
		pulse(2);
		rdc(RTCSI_OFF_FLAGS, 32'h07);
		wr(RTCSI_OFF_CLR, 32'h02);
		rdc(RTCSI_OFF_FLAGS, 32'h05);
		wr(RTCSI_OFF_CLR, 32'h05);
		rdc(RTCSI_OFF_FLAGS, 32'h00);
	endtask : t_flags

	task t_select;
		for (int s = 0; s < 4; s++)
		begin
			wr(RTCSI_OFF_CTRL, (32'(s) << RTCSI_CR_HMS_SEL_LSB)
				| (32'(s) << RTCSI_CR_DMY_SEL_LSB));
			for (int i = 3; i < 10; i++)
				if (i != 3 + s && i != 7 + ((s > 1) ? 2 : s))
					pulse(i);
			rdc(RTCSI_OFF_FLAGS, 32'h00);
			pulse(3 + s);
			rdc(RTCSI_OFF_FLAGS, 32'h08);
			pulse(7 + ((s > 1) ? 2 : s));
			rdc(RTCSI_OFF_FLAGS, 32'h18);
			wr(RTCSI_OFF_CLR, 32'h1F);
		end
	endtask : t_select

	task t_irq;
		wr(RTCSI_OFF_IEN, 32'h15);
		rdc(RTCSI_OFF_IMSK, 32'h15);
		wr(RTCSI_OFF_IEN, 32'h00);
		rdc(RTCSI_OFF_IMSK, 32'h15);
		wr(RTCSI_OFF_IDIS, 32'h10);
		rdc(RTCSI_OFF_IMSK, 32'h05);
		wr(RTCSI_OFF_IDIS, 32'h00);
		rdc(RTCSI_OFF_IMSK, 32'h05);
		pulse(1);
		irq_is(1'b0);
		pulse(0);
		irq_is(1'b1);
		wr(RTCSI_OFF_CLR, 32'h01);
		irq_is(1'b0);
		wr(RTCSI_OFF_IEN, 32'h02);
		irq_is(1'b1);
		wr(RTCSI_OFF_IDIS, 32'h1F);
		irq_is(1'b0);
		rdc(RTCSI_OFF_IMSK, 32'h00);
	endtask : t_irq

	task t_misc;
		logic [31:0] rd;
		logic        er;
		bad <= 4'hA;
		wr(RTCSI_OFF_BAD, 32'h0000_000F);
		rdc(RTCSI_OFF_BAD, 32'h0000_000A);
		wr(RTCSI_OFF_CLR, 32'h1F);
		wr(RTCSI_OFF_CTRL, 32'h0000_0003);
		@(negedge clk_i);
		chk1(treq, 1'b1);
		chk1(dreq, 1'b1);
		pulse(0);
		rdc(RTCSI_OFF_FLAGS, 32'h01);
		rdc(RTCSI_OFF_CLR, 32'h00);
		apb(1'b0, 8'hFC, 32'h0, rd, er);
		chk1(er, 1'b1);
		chk32(rd, 32'h0);
	endtask : t_misc

	// clock enable low must swallow an event; a second reset clears all
	task t_freeze;
		wr(RTCSI_OFF_IEN, 32'h01);
		irq_is(1'b1);
		@(posedge clk_i);
		ce <= 1'b0;
		pulse(2);
		repeat (2) @(posedge clk_i);
		ce <= 1'b1;
		rdc(RTCSI_OFF_FLAGS, 32'h01);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		chk1(irq, 1'b0);
		chk1(treq, 1'b0);
		chk1(dreq, 1'b0);
		rdc(RTCSI_OFF_FLAGS, 32'h00);
		rdc(RTCSI_OFF_IMSK, 32'h00);
	endtask : t_freeze

	initial
	begin
		rstn_i = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 10'h000;
		bad = 4'h0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_flags();
		t_select();
		t_irq();
		t_misc();
		t_freeze();
		complete_run();
	end

endmodule : testbench
